// *** ado_pkg.sv ***
package ado_pkg;
  // ==========================================================
  // Widths
  localparam int unsigned ADO_RES_W = 18;
  localparam int unsigned ADO_IQ_W = 24;
  localparam int unsigned ADO_WORD_W = 48;
  localparam int unsigned ADO_NCO_W = 24;
  localparam int unsigned ADO_LO_W = 16;
  localparam int unsigned ADO_PROD_W = 34;
  localparam int unsigned ADO_ACC_W = 28;
  localparam int unsigned ADO_PAD_W = 2;
  localparam int unsigned ADO_TEMP_W = 10;
  localparam int unsigned ADO_REG_W = 16;
  localparam int unsigned ADO_ADR_W = 8;
  localparam int unsigned ADO_WB_DW = 32;
  localparam int unsigned ADO_WB_AW = 8;
  // ==========================================================
  // Device register offsets, bank 1
  localparam logic [7:0] ADO_REG_FMT_AVG = 8'h0D;
  localparam logic [7:0] ADO_REG_TEMP_CTL = 8'h90;
  localparam logic [7:0] ADO_REG_TEMP_RES = 8'h91;
  localparam logic [7:0] ADO_REG_FCLK_INIT = 8'hC0;
  localparam logic [7:0] ADO_REG_REF_PWR = 8'hC1;
  localparam logic [7:0] ADO_REG_INIT_BC = 8'hC4;
  localparam logic [7:0] ADO_REG_OCLK_C = 8'hC5;
  localparam logic [7:0] ADO_REG_PH_LO = 8'hFC;
  localparam logic [7:0] ADO_REG_PH_FQ = 8'hFD;
  localparam logic [7:0] ADO_REG_FQ_HI = 8'hFE;
  localparam logic [15:0] ADO_REG_RST = 16'h0000;
  // ==========================================================
  // Field positions
  localparam int unsigned ADO_FMT_BIN_BIT = 0;
  localparam int unsigned ADO_RATIO_LSB = 2;
  localparam int unsigned ADO_AVG_EN_BIT = 6;
  localparam int unsigned ADO_DDC_EN_BIT = 7;
  localparam int unsigned ADO_FCLK_LSB = 7;
  localparam int unsigned ADO_INITA_LSB = 10;
  localparam int unsigned ADO_INITC_BIT = 1;
  localparam int unsigned ADO_INITB_LSB = 4;
  localparam int unsigned ADO_OCLKC_BIT = 9;
  localparam int unsigned ADO_REFPD_BIT = 4;
  localparam int unsigned ADO_FQ_LO_LSB = 8;
  // ==========================================================
  // Values
  localparam logic [15:0] ADO_TEMP_LOAD = 16'h4000;
  localparam logic [15:0] ADO_TEMP_END = 16'h0000;
  localparam logic [23:0] ADO_NCO_MASK = 24'hFFFFF0;
  localparam logic [17:0] ADO_SIGN_FLIP = 18'h20000;
  localparam logic [1:0] ADO_INITB_VAL = 2'h2;
  // ==========================================================
  // Host controller registers and commands
  localparam logic [7:0] ADO_HR_CMD = 8'h00;
  localparam logic [7:0] ADO_HR_ARG = 8'h04;
  localparam logic [7:0] ADO_HR_STAT = 8'h08;
  localparam int unsigned ADO_ARG_RATIO_LSB = 8;
  localparam int unsigned ADO_ARG_LANE2_BIT = 12;
  localparam int unsigned ADO_ARG_DDC_BIT = 13;
  localparam int unsigned ADO_ARG_BIN_BIT = 14;
  localparam int unsigned ADO_ARG_DATA_LSB = 16;
  localparam int unsigned ADO_STAT_BUSY_BIT = 16;

  typedef enum logic [2:0] {
    ADO_OP_NONE = 3'b000,
    ADO_OP_WRITE = 3'b001,
    ADO_OP_READ = 3'b010,
    ADO_OP_TEMP = 3'b011,
    ADO_OP_AVG = 3'b100,
    ADO_OP_SYNC = 3'b101,
    ADO_OP_EXTREF = 3'b110
  } ado_op_e;

  typedef enum logic [1:0] {
    ADO_HS_IDLE = 2'b00,
    ADO_HS_ISSUE = 2'b01,
    ADO_HS_WAIT = 2'b10
  } ado_hs_e;
endpackage

// *** ado_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface ado_link_if;
  import ado_pkg::*;
  logic reg_wr;
  logic reg_rd;
  logic [ADO_ADR_W-1:0] reg_addr;
  logic [ADO_REG_W-1:0] reg_wdata;
  logic [ADO_REG_W-1:0] reg_rdata;
  logic reg_ack;
  logic sample_sync_in;
  logic [ADO_WORD_W-1:0] word_a;
  logic [ADO_WORD_W-1:0] word_b;
  logic word_valid;

  modport dev (
    input reg_wr, reg_rd, reg_addr, reg_wdata, sample_sync_in,
    output reg_rdata, reg_ack, word_a, word_b, word_valid
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata, sample_sync_in,
    input reg_rdata, reg_ack, word_a, word_b, word_valid
  );
endinterface
`default_nettype wire

// *** ado_chan.sv ***
`timescale 1ns/100ps
`default_nettype none
module ado_chan
  import ado_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Sample and oscillator tones
  input wire logic signed [ADO_RES_W-1:0] smp_i,
  input wire logic signed [ADO_LO_W-1:0] cos_i,
  input wire logic signed [ADO_LO_W-1:0] sin_i,
  // Controls
  input wire logic fmt_bin_i,
  input wire logic ddc_en_i,
  input wire logic avg_en_i,
  input wire logic sync_i,
  input wire logic [1:0] ratio_i,
  // Result
  output logic [ADO_WORD_W-1:0] word_o,
  output logic valid_o
);
  logic signed [ADO_PROD_W-1:0] prod_i, prod_q;
  logic signed [ADO_IQ_W-1:0] in_i, in_q, avg_i, avg_q, src_i, src_q;
  logic signed [ADO_ACC_W-1:0] acc_i, acc_q, sum_i, sum_q;
  logic [2:0] shift;
  logic [3:0] cnt, last;
  logic [ADO_RES_W-1:0] res;
  logic [ADO_WORD_W-1:0] pack;

  // ==========================================================
  // Mixer
  // complex mix with oscillator
  assign prod_i = smp_i * cos_i;
  assign prod_q = -(smp_i * sin_i);
  assign in_i = ddc_en_i ? prod_i[ADO_PROD_W-1 -: ADO_IQ_W] :
    {{(ADO_IQ_W-ADO_RES_W){smp_i[ADO_RES_W-1]}}, smp_i};
  assign in_q = ddc_en_i ? prod_q[ADO_PROD_W-1 -: ADO_IQ_W] :
    {ADO_IQ_W{1'b0}};

  // ==========================================================
  // Averaging
  assign shift = {1'b0, ratio_i} + 3'd1;
  assign last = (4'h1 << shift) - 4'h1;
  assign sum_i = acc_i + {{(ADO_ACC_W-ADO_IQ_W){in_i[ADO_IQ_W-1]}}, in_i};
  assign sum_q = acc_q + {{(ADO_ACC_W-ADO_IQ_W){in_q[ADO_IQ_W-1]}}, in_q};
  assign avg_i = ADO_IQ_W'(sum_i >>> shift);
  assign avg_q = ADO_IQ_W'(sum_q >>> shift);
  assign src_i = avg_en_i ? avg_i : in_i;
  assign src_q = avg_en_i ? avg_q : in_q;

  assign res = src_i[ADO_RES_W-1:0] ^ (fmt_bin_i ? ADO_SIGN_FLIP : '0);

  always_comb begin
    if (ddc_en_i) begin
      pack = {src_i, src_q};
    end else begin
      pack = {{(ADO_WORD_W-ADO_RES_W-ADO_PAD_W){1'b0}}, res,
        {ADO_PAD_W{1'b0}}};
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_i <= '0;
      acc_q <= '0;
      cnt <= 4'h0;
      word_o <= '0;
      valid_o <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      // Pass mode has no filter state, so sync must not drop a sample
      if (sync_i && avg_en_i) begin
        acc_i <= '0;
        acc_q <= '0;
        cnt <= 4'h0;
      end else if (avg_en_i) begin
        if (cnt == last) begin
          acc_i <= '0;
          acc_q <= '0;
          cnt <= 4'h0;
          word_o <= pack;
          valid_o <= 1'b1;
        end else begin
          acc_i <= sum_i;
          acc_q <= sum_q;
          cnt <= cnt + 4'h1;
        end
      end else begin
        acc_i <= '0;
        acc_q <= '0;
        cnt <= 4'h0;
        word_o <= pack;
        valid_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** ado_dev_end.sv ***
// Function
// - Sample both channels on one edge
// - Format select binary or two's complement
// - Same code format on both channels
// - Reference power-down bit disables internal reference
// - Temperature result readable any time
// - Writing load command captures sensor result
// - Host reads result then ends sequence
// - Filter averages and lowers output rate
// - Sync pulse resets decimation filter
// - Host initializes filter before averaging
// - Ratio codes select averaging by two-sixteen
// - Mixer with 24-bit oscillator gives IQ
// - Each channel outputs 48-bit IQ word
// - One oscillator shared by both channels
// - Frequency word masked, accumulated per sample
// - Sync resets oscillator to initial phase
// - Initial phase word masked, full turn
// - Down-converter decimation by two-sixteen only; with averaging off the code outputs every mixed sample undecimated
// - Host init writes for decimation four-sixteen
// - Sync captured on falling clock edge
// - Two pad bits carry no data
`timescale 1ns/100ps
`default_nettype none
module ado_dev_end
  import ado_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Converter core
  input wire logic [ADO_RES_W-1:0] adc_a_i,
  input wire logic [ADO_RES_W-1:0] adc_b_i,
  input wire logic [ADO_TEMP_W-1:0] temp_code_i,
  output logic int_ref_en_o,
  // Link to host
  ado_link_if.dev lnk
);
  localparam logic [15:0] ADO_WAVE [0:8] = '{
    16'h0000, 16'h18F9, 16'h30FB, 16'h471C, 16'h5A82,
    16'h6A6D, 16'h7641, 16'h7D8A, 16'h7FFF
  };

  logic [ADO_REG_W-1:0] fmt_avg, temp_ctl, temp_res, fclk_init;
  logic [ADO_REG_W-1:0] ref_pwr, init_bc, oclk_c, ph_lo, ph_fq, fq_hi;
  logic [ADO_REG_W-1:0] rd_mux;
  logic [ADO_TEMP_W-1:0] temp_s1, temp_s2;
  logic [ADO_RES_W-1:0] smp_a, smp_b;
  logic sync_fall, sync_d, sync_d2, sync_pulse;
  logic [1:0] act_ratio;
  logic [3:0] ratio_fld;
  logic act_ddc;
  logic [ADO_NCO_W-1:0] act_freq, phase_word, nco_acc;
  logic signed [ADO_LO_W-1:0] lo_cos, lo_sin;
  logic valid_a, valid_b;

  function automatic logic signed [15:0] ado_wave(
    input logic [1:0] q,
    input logic [2:0] i
  );
    logic [15:0] mag;
    mag = q[0] ? ADO_WAVE[4'd8 - {1'b0, i}] : ADO_WAVE[{1'b0, i}];
    ado_wave = q[1] ? -$signed(mag) : $signed(mag);
  endfunction

  // ==========================================================
  // Register port
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fmt_avg <= ADO_REG_RST;
      temp_ctl <= ADO_REG_RST;
      fclk_init <= ADO_REG_RST;
      ref_pwr <= ADO_REG_RST;
      init_bc <= ADO_REG_RST;
      oclk_c <= ADO_REG_RST;
      ph_lo <= ADO_REG_RST;
      ph_fq <= ADO_REG_RST;
      fq_hi <= ADO_REG_RST;
    end else if (lnk.reg_wr) begin
      case (lnk.reg_addr)
        ADO_REG_FMT_AVG: fmt_avg <= lnk.reg_wdata;
        ADO_REG_TEMP_CTL: temp_ctl <= lnk.reg_wdata;
        ADO_REG_FCLK_INIT: fclk_init <= lnk.reg_wdata;
        ADO_REG_REF_PWR: ref_pwr <= lnk.reg_wdata;
        ADO_REG_INIT_BC: init_bc <= lnk.reg_wdata;
        ADO_REG_OCLK_C: oclk_c <= lnk.reg_wdata;
        ADO_REG_PH_LO: ph_lo <= lnk.reg_wdata;
        ADO_REG_PH_FQ: ph_fq <= lnk.reg_wdata;
        ADO_REG_FQ_HI: fq_hi <= lnk.reg_wdata;
        default: ;
      endcase
    end
  end

  // Sensor code settles slowly and arrives unclocked
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      temp_s1 <= '0;
      temp_s2 <= '0;
      temp_res <= ADO_REG_RST;
    end else begin
      temp_s1 <= temp_code_i;
      temp_s2 <= temp_s1;
      if (lnk.reg_wr && lnk.reg_addr == ADO_REG_TEMP_CTL &&
          lnk.reg_wdata == ADO_TEMP_LOAD) begin
        temp_res <= {{(ADO_REG_W-ADO_TEMP_W){1'b0}}, temp_s2};
      end
    end
  end

  always_comb begin
    case (lnk.reg_addr)
      ADO_REG_FMT_AVG: rd_mux = fmt_avg;
      ADO_REG_TEMP_CTL: rd_mux = temp_ctl;
      ADO_REG_TEMP_RES: rd_mux = temp_res;
      ADO_REG_FCLK_INIT: rd_mux = fclk_init;
      ADO_REG_REF_PWR: rd_mux = ref_pwr;
      ADO_REG_INIT_BC: rd_mux = init_bc;
      ADO_REG_OCLK_C: rd_mux = oclk_c;
      ADO_REG_PH_LO: rd_mux = ph_lo;
      ADO_REG_PH_FQ: rd_mux = ph_fq;
      ADO_REG_FQ_HI: rd_mux = fq_hi;
      default: rd_mux = ADO_REG_RST;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lnk.reg_rdata <= ADO_REG_RST;
      lnk.reg_ack <= 1'b0;
    end else begin
      lnk.reg_ack <= lnk.reg_wr | lnk.reg_rd;
      if (lnk.reg_rd) begin
        lnk.reg_rdata <= rd_mux;
      end
    end
  end

  assign int_ref_en_o = ~ref_pwr[ADO_REFPD_BIT];

  // ==========================================================
  // Sync capture
  // latched on falling edge
  always_ff @(negedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_fall <= 1'b0;
    end else begin
      sync_fall <= lnk.sample_sync_in;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_d <= 1'b0;
      sync_d2 <= 1'b0;
    end else begin
      sync_d <= sync_fall;
      sync_d2 <= sync_d;
    end
  end
  assign sync_pulse = sync_d & ~sync_d2;

  // ==========================================================
  // Working settings
  assign ratio_fld = fmt_avg[ADO_RATIO_LSB +: 4];
  assign phase_word = {ph_fq[ADO_FQ_LO_LSB-1:0], ph_lo} & ADO_NCO_MASK;

  // Taking ratio and tuning only at sync keeps the two
  // channels and several devices on a common restart point
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      act_ratio <= 2'd0;
      act_ddc <= 1'b0;
      act_freq <= '0;
    end else if (sync_pulse) begin
      act_ratio <= (ratio_fld > 4'd3) ? 2'd3 : ratio_fld[1:0];
      act_ddc <= fmt_avg[ADO_DDC_EN_BIT];
      act_freq <= {fq_hi, ph_fq[ADO_REG_W-1:ADO_FQ_LO_LSB]} &
        ADO_NCO_MASK;
    end
  end

  // ==========================================================
  // Oscillator
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nco_acc <= '0;
    end else if (sync_pulse) begin
      nco_acc <= phase_word;
    end else begin
      nco_acc <= nco_acc + act_freq;
    end
  end

  assign lo_sin = ado_wave(nco_acc[ADO_NCO_W-1 -: 2],
    nco_acc[ADO_NCO_W-3 -: 3]);
  assign lo_cos = ado_wave(nco_acc[ADO_NCO_W-1 -: 2] + 2'd1,
    nco_acc[ADO_NCO_W-3 -: 3]);

  // ==========================================================
  // Sampling
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      smp_a <= '0;
      smp_b <= '0;
    end else begin
      smp_a <= adc_a_i ^ ADO_SIGN_FLIP;
      smp_b <= adc_b_i ^ ADO_SIGN_FLIP;
    end
  end

  ado_chan u_chan_a (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .smp_i(smp_a),
    .cos_i(lo_cos),
    .sin_i(lo_sin),
    .fmt_bin_i(fmt_avg[ADO_FMT_BIN_BIT]),
    .ddc_en_i(act_ddc),
    .avg_en_i(fmt_avg[ADO_AVG_EN_BIT]),
    .sync_i(sync_pulse),
    .ratio_i(act_ratio),
    .word_o(lnk.word_a),
    .valid_o(valid_a)
  );

  ado_chan u_chan_b (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .smp_i(smp_b),
    .cos_i(lo_cos),
    .sin_i(lo_sin),
    .fmt_bin_i(fmt_avg[ADO_FMT_BIN_BIT]),
    .ddc_en_i(act_ddc),
    .avg_en_i(fmt_avg[ADO_AVG_EN_BIT]),
    .sync_i(sync_pulse),
    .ratio_i(act_ratio),
    .word_o(lnk.word_b),
    .valid_o(valid_b)
  );

  // Channels run in lockstep; a word is framed only when both agree
  assign lnk.word_valid = valid_a & valid_b;
endmodule
`default_nettype wire

// *** ado_host_end.sv ***
`timescale 1ns/100ps
`default_nettype none
module ado_host_end
  import ado_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADO_WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADO_WB_DW-1:0] wb_dat_i,
  output logic [ADO_WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Received samples
  output logic [ADO_WORD_W-1:0] samp_a_o,
  output logic [ADO_WORD_W-1:0] samp_b_o,
  output logic samp_valid_o,
  // Link to device
  ado_link_if.host lnk
);
  logic [ADO_WB_DW-1:0] arg;
  logic [ADO_REG_W-1:0] rdata;
  ado_op_e op;
  ado_hs_e state;
  logic [2:0] step, eff;
  logic wb_wr, short, st_rd, st_last;
  logic [1:0] ratio;
  logic [2:0] fclk;
  logic [1:0] init_a;
  logic [ADO_ADR_W-1:0] st_addr;
  logic [ADO_REG_W-1:0] st_data;

  // ==========================================================
  // Wishbone slave
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      arg <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        case (wb_adr_i)
          ADO_HR_ARG: wb_dat_o <= arg;
          ADO_HR_STAT: wb_dat_o <= {{(ADO_WB_DW-ADO_STAT_BUSY_BIT-1){1'b0}},
            state != ADO_HS_IDLE, rdata};
          default: wb_dat_o <= '0;
        endcase
      end
      if (wb_wr && wb_adr_i == ADO_HR_ARG) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            arg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end
    end
  end

  // ==========================================================
  // Step table
  assign ratio = arg[ADO_ARG_RATIO_LSB +: 2];
  assign short = arg[ADO_ARG_DDC_BIT] && ratio == 2'd0;
  assign eff = short ? step + 3'd2 : step;

  always_comb begin
    if (arg[ADO_ARG_DDC_BIT]) begin
      fclk = (ratio <= 2'd1) ? 3'd0 : {1'b0, ratio} + 3'd2;
      init_a = short ? 2'd0 : 2'd1;
    end else begin
      fclk = (ratio == 2'd0) ? 3'd0 : {1'b0, ratio} + 3'd3;
      init_a = arg[ADO_ARG_LANE2_BIT] ? 2'd1 : 2'd0;
    end
  end

  always_comb begin
    st_rd = 1'b0;
    st_last = 1'b1;
    st_addr = arg[ADO_ADR_W-1:0];
    st_data = arg[ADO_ARG_DATA_LSB +: ADO_REG_W];
    unique case (op)
      ADO_OP_READ: st_rd = 1'b1;
      ADO_OP_TEMP: begin
        st_last = (step == 3'd2);
        st_rd = (step == 3'd1);
        st_addr = (step == 3'd1) ? ADO_REG_TEMP_RES : ADO_REG_TEMP_CTL;
        st_data = (step == 3'd0) ? ADO_TEMP_LOAD : ADO_TEMP_END;
      end
      ADO_OP_AVG: begin
        st_last = (eff == 3'd3);
        st_data = '0;
        case (eff)
          3'd0: begin
            st_addr = ADO_REG_OCLK_C;
            st_data[ADO_OCLKC_BIT] = 1'b1;
          end
          3'd1: begin
            st_addr = ADO_REG_INIT_BC;
            st_data[ADO_INITB_LSB +: 2] = ADO_INITB_VAL;
            st_data[ADO_INITC_BIT] = 1'b1;
          end
          3'd2: begin
            st_addr = ADO_REG_FCLK_INIT;
            st_data[ADO_INITA_LSB +: 2] = init_a;
            st_data[ADO_FCLK_LSB +: 3] = fclk;
          end
          default: begin
            st_addr = ADO_REG_FMT_AVG;
            st_data[ADO_AVG_EN_BIT] = 1'b1;
            st_data[ADO_RATIO_LSB +: 2] = ratio;
            st_data[ADO_DDC_EN_BIT] = arg[ADO_ARG_DDC_BIT];
            st_data[ADO_FMT_BIN_BIT] = arg[ADO_ARG_BIN_BIT];
          end
        endcase
      end
      ADO_OP_EXTREF: begin
        st_addr = ADO_REG_REF_PWR;
        st_data = '0;
        st_data[ADO_REFPD_BIT] = 1'b1;
      end
      default: ;
    endcase
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ADO_HS_IDLE;
      op <= ADO_OP_NONE;
      step <= 3'd0;
      rdata <= '0;
      lnk.reg_wr <= 1'b0;
      lnk.reg_rd <= 1'b0;
      lnk.reg_addr <= '0;
      lnk.reg_wdata <= '0;
      lnk.sample_sync_in <= 1'b0;
    end else begin
      lnk.reg_wr <= 1'b0;
      lnk.reg_rd <= 1'b0;
      lnk.sample_sync_in <= 1'b0;
      unique case (state)
        ADO_HS_IDLE: begin
          // Orders that arrive while busy are dropped
          if (wb_wr && wb_adr_i == ADO_HR_CMD && wb_sel_i[0] &&
              wb_dat_i[2:0] != ADO_OP_NONE && wb_dat_i[2:0] != 3'b111) begin
            op <= ado_op_e'(wb_dat_i[2:0]);
            step <= 3'd0;
            state <= ADO_HS_ISSUE;
          end
        end
        ADO_HS_ISSUE: begin
          if (op == ADO_OP_SYNC) begin
            lnk.sample_sync_in <= 1'b1;
          end else begin
            lnk.reg_wr <= ~st_rd;
            lnk.reg_rd <= st_rd;
            lnk.reg_addr <= st_addr;
            lnk.reg_wdata <= st_data;
          end
          state <= ADO_HS_WAIT;
        end
        ADO_HS_WAIT: begin
          if (op == ADO_OP_SYNC) begin
            state <= ADO_HS_IDLE;
          end else if (lnk.reg_ack) begin
            if (st_rd) begin
              rdata <= lnk.reg_rdata;
            end
            if (st_last) begin
              state <= ADO_HS_IDLE;
            end else begin
              step <= step + 3'd1;
              state <= ADO_HS_ISSUE;
            end
          end
        end
        default: state <= ADO_HS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Sample capture
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      samp_a_o <= '0;
      samp_b_o <= '0;
      samp_valid_o <= 1'b0;
    end else begin
      samp_valid_o <= lnk.word_valid;
      if (lnk.word_valid) begin
        samp_a_o <= lnk.word_a;
        samp_b_o <= lnk.word_b;
      end
    end
  end
endmodule
`default_nettype wire

// *** ado_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module ado_assertions
  import ado_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Link
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADO_ADR_W-1:0] reg_addr,
  input wire logic [ADO_REG_W-1:0] reg_wdata,
  input wire logic [ADO_REG_W-1:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic sample_sync_in,
  input wire logic [ADO_WORD_W-1:0] word_a,
  input wire logic [ADO_WORD_W-1:0] word_b,
  input wire logic word_valid
);
  logic avg_on;
  logic ddc_seen;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================
  // Mode mirror; pad check stops once ddc is ever set
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avg_on <= 1'b0;
      ddc_seen <= 1'b0;
    end else if (reg_wr && reg_addr == ADO_REG_FMT_AVG) begin
      avg_on <= reg_wdata[ADO_AVG_EN_BIT];
      ddc_seen <= ddc_seen | reg_wdata[ADO_DDC_EN_BIT];
    end
  end
  // ==========================================
  // Properties
  sequence s_req; reg_wr || reg_rd; endsequence
  sequence s_avg; avg_on [*4]; endsequence
  chk_ack_timing: assert property (s_req |=> reg_ack)
    else $error("link ack late");
  chk_req_spacing: assert property (
    s_req |=> !(reg_wr || reg_rd) [*2]) else $error("requests too close");
  chk_temp_width: assert property (
    (reg_rd && reg_addr == ADO_REG_TEMP_RES) |=> reg_rdata[15:10] == 6'h00)
    else $error("temperature too wide");
  chk_pass_rate: assert property ((!avg_on) [*3] |-> word_valid)
    else $error("sample dropped");
  chk_avg_rate: assert property (s_avg ##0 word_valid |=> !word_valid)
    else $error("rate not lowered");
  chk_sync_restart: assert property (
    s_avg ##0 sample_sync_in |-> ##[2:40] word_valid)
    else $error("no output after sync");
  chk_sync_pulse: assert property (
    sample_sync_in |=> !sample_sync_in) else $error("sync too long");
  chk_pad_bits: assert property (
    word_valid && !ddc_seen |-> word_a[1:0] == 2'h0 && word_b[1:0] == 2'h0
    && word_a[47:20] == 28'h0) else $error("pad bits set");
endmodule
`default_nettype wire

// *** adc_digital_output_path_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_digital_output_path_test
  import ado_pkg::*;
;
  logic clk, rst_n, cyc, stb, we, ack, ref_en, s_vld;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q;
  logic [17:0] adc_a, adc_b;
  logic [47:0] s_a, s_b;
  int n_fail, n_compared, g;
  ado_link_if lnk();
  ado_dev_end u_ado_dev_end(.clk_sys_i(clk), .reset_n_i(rst_n),
    .adc_a_i(adc_a), .adc_b_i(adc_b), .temp_code_i(10'h2A5),
    .int_ref_en_o(ref_en), .lnk(lnk));
  ado_host_end u_ado_host_end(.clk_sys_i(clk), .reset_n_i(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .samp_a_o(s_a), .samp_b_o(s_b), .samp_valid_o(s_vld), .lnk(lnk));
  ado_assertions u_ado_assertions(.clk_sys_i(clk), .reset_n_i(rst_n),
    .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_addr(lnk.reg_addr),
    .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata),
    .reg_ack(lnk.reg_ack), .sample_sync_in(lnk.sample_sync_in),
    .word_a(lnk.word_a), .word_b(lnk.word_b), .word_valid(lnk.word_valid));
  // ==========================================
  // Tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] arg, input ado_op_e op);
    wb(1'b1, ADO_HR_ARG, arg);
    wb(1'b1, ADO_HR_CMD, 32'(op));
    do wb(1'b0, ADO_HR_STAT, 32'h0); while (q[ADO_STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Spacing in clocks between two output words
  task automatic gap();
    g = 0;
    do @(posedge clk); while (s_vld !== 1'b1);
    do begin
      @(posedge clk);
      g++;
    end while (s_vld !== 1'b1 && g < 64);
  endtask
  task end_sim;
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole run is a few hundred clocks
  initial begin
    #800000;
    n_fail++;
    end_sim;
  end
  initial begin
    {rst_n, cyc, stb, we, adr, dat, adc_b} = '0;
    adc_a = 18'h3FFFF;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk(48'(ref_en), 48'h1);
    wb(1'b0, 8'h20, 32'h0);
    chk(48'(q), 48'h0);
    cmd(32'h0, ADO_OP_EXTREF);
    chk(48'(ref_en), 48'h0);
    cmd(32'h0, ADO_OP_TEMP);
    wb(1'b0, ADO_HR_STAT, 32'h0);
    chk(48'(q[15:0]), 48'h2A5);
    for (int f = 0; f < 2; f++) begin
      cmd({16'(f), 8'h00, ADO_REG_FMT_AVG}, ADO_OP_WRITE);
      repeat (6) @(posedge clk);
      chk(s_a, {28'h0, f ? 18'h3FFFF : 18'h1FFFF, 2'h0});
      chk(s_b, {28'h0, f ? 18'h00000 : 18'h20000, 2'h0});
    end
    for (int r = 0; r < 4; r++) begin
      cmd({17'h0, 1'b1, 4'h0, 2'(r), 8'h00}, ADO_OP_AVG);
      cmd(32'h0, ADO_OP_SYNC);
      gap();
      gap();
      chk(48'(g), 48'(2 ** (r + 1)));
      chk(s_a, {28'h0, 18'h3FFFF, 2'h0});
    end
    cmd(32'(ADO_REG_FCLK_INIT), ADO_OP_READ);
    wb(1'b0, ADO_HR_STAT, 32'h0);
    chk(48'(q[15:0]), 48'h0300);
    adc_b <= 18'h3FFFF;
    cmd({17'h0, 1'b1, 1'b1, 13'h0}, ADO_OP_AVG);
    cmd(32'h0, ADO_OP_SYNC);
    gap();
    gap();
    chk(48'(g), 48'h2);
    chk(s_a, s_b);
    chk(s_a, {24'h3FFF60, 24'h000000});
    cmd({17'h0, 1'b1, 1'b1, 3'h0, 2'h1, 8'h00}, ADO_OP_AVG);
    cmd(32'(ADO_REG_FCLK_INIT), ADO_OP_READ);
    wb(1'b0, ADO_HR_STAT, 32'h0);
    chk(48'(q[15:0]), 48'h0400);
    end_sim;
  end
endmodule
`default_nettype wire
